/* File: common/atc_pkg.sv */
// ************************************************************
// amplifier trim control package
// ************************************************************
package atc_pkg;

    // register offsets (own choice, byte wide registers)
    localparam logic [3:0] ATC_OFF_AMP0_CONTROL     = 4'h0;
    localparam logic [3:0] ATC_OFF_AMP1_CONTROL     = 4'h1;
    localparam logic [3:0] ATC_OFF_AMP0_OFFSET_TRIM = 4'h2;
    localparam logic [3:0] ATC_OFF_AMP1_OFFSET_TRIM = 4'h3;
    localparam logic [3:0] ATC_OFF_GAIN_RES         = 4'h4;

    // field positions in control register
    localparam int ATC_CTL_ENABLE_BIT = 6;
    localparam int ATC_CTL_STATUS_BIT = 5;
    // field positions in calibration register
    localparam int ATC_CAL_MODE_BIT   = 7;
    localparam int ATC_CAL_REF_BIT    = 6;

    // reset values
    localparam logic [7:0] ATC_CONTROL_RST  = 8'h00;
    localparam logic [7:0] ATC_TRIM_RST     = 8'h20;
    localparam logic [7:0] ATC_GAIN_RES_RST = 8'h00;

    // bandwidth selector codes
    typedef enum logic [1:0] {
        ATC_BW_5KHZ   = 2'b00,
        ATC_BW_40KHZ  = 2'b01,
        ATC_BW_600KHZ = 2'b10,
        ATC_BW_2MHZ   = 2'b11
    } atc_bw_t;

    // analogue controls for one amplifier
    typedef struct packed {
        logic       enable;
        atc_bw_t    bandwidth_sel;
        logic       cal_mode;
        logic       cal_ref_sel;
        logic [5:0] trim_code;
    } atc_amp_ctl_t;

    // gain resistor controls
    typedef struct packed {
        logic [1:0] res_c_code;
        logic [5:0] res_b_code;
    } atc_gain_t;

endpackage : atc_pkg

/* File: rtl/atc_amp_trim_control_regs.sv */
// Contract
// (RULE1) control bit 6 enables amplifier, resets 0
// (RULE2) control bit 5 read-only amplifier status
// (RULE3) status reads 0 outside calibration mode
// (RULE4) control bits 1:0 select bandwidth
// (RULE5) calibration bit 7 selects calibration mode
// (RULE6) calibration bit 6 selects reference input
// (RULE7) six-bit trim code, register resets 0x20
// (RULE8) gain bits 5:0 times 100 kilohm
// (RULE9) control bits 7, 4:2 read zero
// (RULE10) software sets shared pins before calibrating
// (RULE11) software sets mode and reference both
// (RULE12) software scans trim upward from zero
// (RULE13) software scans trim downward from full
// (RULE14) software writes back truncated average
// (RULE15) gain bits 7:6 select 10-40 kilohm
// (RULE16) amp1 bandwidth uses same encoding
// (RULE17) new trim reaches amplifier next clock
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module atc_amp_trim_control_regs
    import atc_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [1:0]  i_amp_out,
    output logic      [7:0]  o_rdata,
    output atc_amp_ctl_t     o_amp0,
    output atc_amp_ctl_t     o_amp1,
    output atc_gain_t        o_gain
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [1:0] amp_out_meta;
    logic [1:0] amp_out_sync;

    // two stage capture of comparator levels from the analogue side
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            amp_out_meta <= 2'h0;
            amp_out_sync <= 2'h0;
        end else begin
            amp_out_meta <= i_amp_out;
            amp_out_sync <= amp_out_meta;
        end
    end

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_ctl0;
    logic wr_ctl1;
    logic wr_trim0;
    logic wr_trim1;
    logic wr_gain;

    // one strobe per register
    assign wr_ctl0  = i_wr && (i_addr == ATC_OFF_AMP0_CONTROL);
    assign wr_ctl1  = i_wr && (i_addr == ATC_OFF_AMP1_CONTROL);
    assign wr_trim0 = i_wr && (i_addr == ATC_OFF_AMP0_OFFSET_TRIM);
    assign wr_trim1 = i_wr && (i_addr == ATC_OFF_AMP1_OFFSET_TRIM);
    assign wr_gain  = i_wr && (i_addr == ATC_OFF_GAIN_RES);

    // ************************************************************
    // amplifier control and calibration, one slice per amplifier
    // ************************************************************
    logic [1:0]   wr_ctl;
    logic [1:0]   wr_trim;
    atc_amp_ctl_t amp_ctl [2];

    // per amplifier strobes, index is the amplifier number
    assign wr_ctl  = {wr_ctl1, wr_ctl0};
    assign wr_trim = {wr_trim1, wr_trim0};

    // both amplifiers share layout and encoding
    for (genvar g = 0; g < 2; g++) begin : g_amp
        logic       enable;
        atc_bw_t    bandwidth_sel;
        logic       cal_mode;
        logic       cal_ref_sel;
        logic [5:0] trim_code;

        // only enable and bandwidth are stored, status is never written
        always_ff @(posedge i_ref_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                enable        <= ATC_CONTROL_RST[ATC_CTL_ENABLE_BIT];
                bandwidth_sel <= atc_bw_t'(ATC_CONTROL_RST[1:0]);
            end else if (wr_ctl[g]) begin
                enable        <= i_wdata[ATC_CTL_ENABLE_BIT];   // RULE1
                bandwidth_sel <= atc_bw_t'(i_wdata[1:0]);       // RULE4 RULE16
            end
        end

        // calibration fields drive the trim directly from the register
        always_ff @(posedge i_ref_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                cal_mode    <= ATC_TRIM_RST[ATC_CAL_MODE_BIT];
                cal_ref_sel <= ATC_TRIM_RST[ATC_CAL_REF_BIT];
                trim_code   <= ATC_TRIM_RST[5:0];
            end else if (wr_trim[g]) begin
                cal_mode    <= i_wdata[ATC_CAL_MODE_BIT];   // RULE5
                cal_ref_sel <= i_wdata[ATC_CAL_REF_BIT];    // RULE6
                trim_code   <= i_wdata[5:0];                // RULE7 RULE17
            end
        end

        // fields leave the flops with no logic between
        assign amp_ctl[g] = {enable, bandwidth_sel, cal_mode, cal_ref_sel, trim_code};
    end

    // outputs come straight from the slice registers
    assign o_amp0 = amp_ctl[0];
    assign o_amp1 = amp_ctl[1];

    // ************************************************************
    // gain resistor register
    // ************************************************************
    // low field sets code times 100k, top field picks 10k..40k
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_gain <= ATC_GAIN_RES_RST;
        end else if (wr_gain) begin
            o_gain.res_b_code <= i_wdata[5:0];   // RULE8
            o_gain.res_c_code <= i_wdata[7:6];   // RULE15
        end
    end

    // ************************************************************
    // status and read path
    // ************************************************************
    logic [1:0] out_status;
    logic [7:0] next_rdata;

    // status is masked to zero unless in calibration mode
    assign out_status[0] = o_amp0.cal_mode & amp_out_sync[0];   // RULE2 RULE3
    assign out_status[1] = o_amp1.cal_mode & amp_out_sync[1];   // RULE2 RULE3

    // read mux, unused bits and unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        case (i_addr)
            ATC_OFF_AMP0_CONTROL: begin
                next_rdata = {1'b0, o_amp0.enable, out_status[0], 3'h0, o_amp0.bandwidth_sel};   // RULE9
            end
            ATC_OFF_AMP1_CONTROL: begin
                next_rdata = {1'b0, o_amp1.enable, out_status[1], 3'h0, o_amp1.bandwidth_sel};   // RULE9
            end
            ATC_OFF_AMP0_OFFSET_TRIM: begin
                next_rdata = {o_amp0.cal_mode, o_amp0.cal_ref_sel, o_amp0.trim_code};
            end
            ATC_OFF_AMP1_OFFSET_TRIM: begin
                next_rdata = {o_amp1.cal_mode, o_amp1.cal_ref_sel, o_amp1.trim_code};
            end
            ATC_OFF_GAIN_RES: begin
                next_rdata = o_gain;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data valid one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_trim0_write;
        wr_trim0;
    endsequence

    sequence s_ctl0_read;
        i_rd && (i_addr == ATC_OFF_AMP0_CONTROL);
    endsequence

    sequence s_ctl1_read;
        i_rd && (i_addr == ATC_OFF_AMP1_CONTROL);
    endsequence

    sequence s_trim1_write;
        wr_trim1;
    endsequence

    sequence s_trim0_read;
        i_rd && (i_addr == ATC_OFF_AMP0_OFFSET_TRIM);
    endsequence

    sequence s_gain_read;
        i_rd && (i_addr == ATC_OFF_GAIN_RES);
    endsequence

    property p_enable_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_ctl0 |=> (o_amp0.enable == $past(i_wdata[6]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("amp0 enable not stored"); // RULE1

    property p_status_ro;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_rd && i_addr == ATC_OFF_AMP0_CONTROL) |=> (o_rdata[5] == $past(out_status[0]));
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("amp0 status read wrong"); // RULE2

    property p_status_masked;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (s_ctl0_read ##0 !o_amp0.cal_mode) |=> (o_rdata[5] == 1'b0);
    endproperty
    a_status_masked: assert property (p_status_masked) else $error("status not zero in normal mode"); // RULE3

    property p_bw_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_ctl1 |=> (o_amp1.bandwidth_sel == $past(i_wdata[1:0]));
    endproperty
    a_bw_write: assert property (p_bw_write) else $error("amp1 bandwidth not stored"); // RULE4

    property p_cal_mode_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_trim0_write |=> (o_amp0.cal_mode == $past(i_wdata[7]) && o_amp0.cal_ref_sel == $past(i_wdata[6]));
    endproperty
    a_cal_mode_write: assert property (p_cal_mode_write) else $error("amp0 mode or reference wrong"); // RULE5

    property p_trim_next;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_trim1 |=> (o_amp1.trim_code == $past(i_wdata[5:0]));
    endproperty
    a_trim_next: assert property (p_trim_next) else $error("amp1 trim not applied next clock"); // RULE17

    property p_gain_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_gain |=> (o_gain == $past(i_wdata));
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain register not stored"); // RULE8

    property p_unused_zero;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_ctl0_read |=> (o_rdata[7] == 1'b0 && o_rdata[4:2] == 3'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused control bits not zero"); // RULE9

    property p_trim_hold;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        !wr_trim0 |=> $stable(o_amp0.trim_code);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("amp0 trim changed without write"); // RULE7

    property p_ctl0_hold;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        !wr_ctl0 |=> ($stable(o_amp0.enable) && $stable(o_amp0.bandwidth_sel));
    endproperty
    a_ctl0_hold: assert property (p_ctl0_hold) else $error("amp0 control changed without write"); // RULE1

    property p_enable1_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_ctl1 |=> (o_amp1.enable == $past(i_wdata[ATC_CTL_ENABLE_BIT]));
    endproperty
    a_enable1_write: assert property (p_enable1_write) else $error("amp1 enable not stored"); // RULE1

    property p_bw0_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_ctl0 |=> (o_amp0.bandwidth_sel == $past(i_wdata[1:0]));
    endproperty
    a_bw0_write: assert property (p_bw0_write) else $error("amp0 bandwidth not stored"); // RULE4

    property p_status_follow;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (s_ctl0_read ##0 o_amp0.cal_mode) |=> (o_rdata[ATC_CTL_STATUS_BIT] == $past(amp_out_sync[0]));
    endproperty
    a_status_follow: assert property (p_status_follow) else $error("amp0 status not following output"); // RULE2

    property p_status1_ro;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_ctl1_read |=> (o_rdata[ATC_CTL_STATUS_BIT] == $past(out_status[1]));
    endproperty
    a_status1_ro: assert property (p_status1_ro) else $error("amp1 status read wrong"); // RULE2

    property p_status1_masked;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (s_ctl1_read ##0 !o_amp1.cal_mode) |=> (o_rdata[ATC_CTL_STATUS_BIT] == 1'b0);
    endproperty
    a_status1_masked: assert property (p_status1_masked) else $error("amp1 status not zero in normal mode"); // RULE3

    property p_unused1_zero;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_ctl1_read |=> (o_rdata[7] == 1'b0 && o_rdata[4:2] == 3'h0);
    endproperty
    a_unused1_zero: assert property (p_unused1_zero) else $error("unused amp1 control bits not zero"); // RULE9

    property p_cal1_mode_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_trim1_write |=> (o_amp1.cal_mode == $past(i_wdata[ATC_CAL_MODE_BIT]));
    endproperty
    a_cal1_mode_write: assert property (p_cal1_mode_write) else $error("amp1 mode not stored"); // RULE5

    property p_ref1_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_trim1_write |=> (o_amp1.cal_ref_sel == $past(i_wdata[ATC_CAL_REF_BIT]));
    endproperty
    a_ref1_write: assert property (p_ref1_write) else $error("amp1 reference not stored"); // RULE6

    property p_trim0_next;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_trim0_write |=> (o_amp0.trim_code == $past(i_wdata[5:0]));
    endproperty
    a_trim0_next: assert property (p_trim0_next) else $error("amp0 trim not applied next clock"); // RULE17

    property p_trim1_hold;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        !wr_trim1 |=> $stable(o_amp1.trim_code);
    endproperty
    a_trim1_hold: assert property (p_trim1_hold) else $error("amp1 trim changed without write"); // RULE7

    property p_trim0_read;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_trim0_read |=> (o_rdata == $past({o_amp0.cal_mode, o_amp0.cal_ref_sel, o_amp0.trim_code}));
    endproperty
    a_trim0_read: assert property (p_trim0_read) else $error("amp0 calibration read wrong"); // RULE7

    property p_gain_c_write;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        wr_gain |=> (o_gain.res_c_code == $past(i_wdata[7:6]));
    endproperty
    a_gain_c_write: assert property (p_gain_c_write) else $error("third resistor code not stored"); // RULE15

    property p_gain_hold;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        !wr_gain |=> $stable(o_gain);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain register changed without write"); // RULE8

    property p_gain_read;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        s_gain_read |=> (o_rdata == $past(o_gain));
    endproperty
    a_gain_read: assert property (p_gain_read) else $error("gain register read wrong"); // RULE15

endmodule : atc_amp_trim_control_regs

`default_nettype wire

/* File: testbench/atc_amp_trim_control_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module atc_amp_trim_control_regs_tb
    import atc_pkg::*;
;
    // ************************************************************
    // clock, reset, design and comparator stand-in
    // ************************************************************
    logic         i_ref_clk = 1'b0;
    logic         i_resetn  = 1'b0;
    logic [3:0]   i_addr    = 4'h0;
    logic [7:0]   i_wdata   = 8'h00;
    logic         i_wr      = 1'b0;
    logic         i_rd      = 1'b0;
    logic [1:0]   i_amp_out = 2'b00;
    logic [5:0]   thr0      = 6'h00;
    logic [5:0]   thr1      = 6'h00;
    logic [7:0]   o_rdata;
    atc_amp_ctl_t o_amp0;
    atc_amp_ctl_t o_amp1;
    atc_gain_t    o_gain;
    int           n_mismatch   = 0;
    int           total_checks = 0;

    // 40 MHz clock
    always #12.5 i_ref_clk = ~i_ref_clk;

    // comparator flips once the trim code reaches its threshold
    always @(posedge i_ref_clk) begin
        i_amp_out <= {o_amp1.trim_code >= thr1, o_amp0.trim_code >= thr0};
    end

    atc_amp_trim_control_regs atc_amp_trim_control_regs_inst (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_amp_out(i_amp_out), .o_rdata(o_rdata),
        .o_amp0(o_amp0), .o_amp1(o_amp1), .o_gain(o_gain));

    // ************************************************************
    // register bus tasks
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask : rdchk

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rdchk(4'h0, 8'h00);
        rdchk(4'h1, 8'h00);
        rdchk(4'h2, 8'h20);
        rdchk(4'h3, 8'h20);
        rdchk(4'h4, 8'h00);
        `CHK(o_amp1, 11'h020)
        $display("test reset values done");
    endtask : t_reset

    // comparators held high: status follows calibration mode only
    task automatic t_control();
        wr(4'h0, 8'hff);
        rdchk(4'h0, 8'h43);
        `CHK(o_amp0.enable, 1'b1)
        wr(4'h2, 8'h80);
        repeat (4) @(posedge i_ref_clk);
        rdchk(4'h0, 8'h63);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'hbc);
        rdchk(4'h0, 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(4'h0, 8'(b));
            wr(4'h1, 8'h40 | 8'(b));
            `CHK(o_amp0.bandwidth_sel, atc_bw_t'(b))
            `CHK(o_amp1.bandwidth_sel, atc_bw_t'(b))
            rdchk(4'h1, 8'h40 | 8'(b));
        end
        $display("test control registers done");
    endtask : t_control

    task automatic t_gain();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), 6'(i * 21)};
            wr(4'h4, v);
            `CHK(o_gain, v)
            rdchk(4'h4, v);
        end
        wr(4'h5, 8'hff);
        rdchk(4'h5, 8'h00);
        rdchk(4'h4, v);
        $display("test gain register done");
    endtask : t_gain

    // two-sided trim search as software would run it
    task automatic t_cal(input int n, input logic [5:0] th);
        logic [7:0] d;
        logic       prev;
        int         lo;
        int         hi;
        lo = -1;
        hi = -1;
        for (int k = 0; k < 2; k++) begin
            for (int s = 0; s < 64; s++) begin
                wr(4'(n + 2), 8'hc0 | 8'(k ? 63 - s : s));
                repeat (4) @(posedge i_ref_clk);
                rd(4'(n), d);
                if (s == 0) prev = d[5];
                else if (d[5] !== prev) begin
                    if (k == 0) lo = s;
                    else hi = 63 - s;
                    break;
                end
            end
        end
        `CHK(lo, int'(th))
        `CHK(hi, int'(th) - 1)
        wr(4'(n + 2), 8'hc0 | 8'((lo + hi) / 2));
        `CHK(n ? o_amp1.trim_code : o_amp0.trim_code, th - 6'h01)
        `CHK(n ? o_amp1.cal_ref_sel : o_amp0.cal_ref_sel, 1'b1)
        rdchk(4'(n + 2), 8'hc0 | {2'b00, th - 6'h01});
        $display("test calibration of amplifier %0d done", n);
    endtask : t_cal

    // reset in mid-run brings both trim registers and the gain register back to their defaults
    task automatic t_rerun_reset();
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        rdchk(4'h3, 8'h20);
        rdchk(4'h2, 8'h20);
        `CHK(o_gain, ATC_GAIN_RES_RST)
        $display("test reset in mid-run done");
    endtask : t_rerun_reset

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_reset();
        t_control();
        t_gain();
        thr0 = 6'd23;
        thr1 = 6'd40;
        t_cal(0, 6'd23);
        t_cal(1, 6'd40);
        t_rerun_reset();
        summarize();
    end

    // cuts a hang short
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        n_mismatch++;
        summarize();
    end
endmodule : atc_amp_trim_control_regs_tb

`default_nettype wire
